// file: core/usr_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "usr_params.svh"

module usr_core
  import usr_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst,
  // Register port
  input  wire usr_bus_t  busReq,
  output logic [7:0]     rdData,
  // Serial pins
  output logic           txd,
  output logic           txdOverride,
  input  wire logic      rxd,
  output logic           rxdOverride,
  input  wire logic      syncClkIn,
  output logic           syncClkOverride,
  // Interrupt requests
  output logic           irqTxEmpty,
  output logic           irqTxDone,
  input  wire logic      txDoneAck
);

  // --------------------------------------------------------------------
  // Character helpers
  // --------------------------------------------------------------------
  function automatic logic [3:0] usr_char_bits(input logic [2:0] csz);
    if (csz == `USR_CSZ_NINE) begin
      return 4'h9;
    end
    return 4'h5 + {2'h0, csz[1:0]};
  endfunction : usr_char_bits

  function automatic logic [8:0] usr_char_mask(input logic [2:0] csz);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(usr_char_bits(csz))) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : usr_char_mask

  function automatic logic usr_parity(input logic [8:0] d, input logic [2:0] csz,
                                      input logic odd);
    logic       p;
    logic [8:0] m;
    p = odd;
    m = usr_char_mask(csz);
    for (int i = 0; i < 9; i++) begin
      p = p ^ (d[i] & m[i]);
    end
    return p;
  endfunction : usr_parity

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  usr_state_t s;
  usr_state_t next_s;

  logic       smpTick;
  logic [3:0] lastSub;
  logic       syncRise;
  logic       syncFall;
  logic       txTick;
  logic       rxTick;
  logic       rxIn;
  logic       wrData;
  logic       rdDataReg;

  assign smpTick   = (s.baudCnt == 12'h000);
  assign lastSub   = s.dbl ? `USR_SMP_DOUBLE : `USR_SMP_NORMAL;
  assign syncRise  = syncClkIn & ~s.syncPrev;
  assign syncFall  = ~syncClkIn & s.syncPrev;
  assign txTick    = s.syncMode ? syncRise : (smpTick && s.txSub == lastSub);
  assign rxTick    = s.syncMode ? syncFall : (smpTick && s.rxSub == lastSub);
  assign rxIn      = s.receive_enable ? rxd : 1'b1;
  assign wrData    = busReq.wr && busReq.addr == `USR_ADDR_DATA;
  assign rdDataReg = busReq.rd && busReq.addr == `USR_ADDR_DATA;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic finish;
    next_s   = s;
    finish   = 1'b0;
    next_s.syncPrev = syncClkIn;
    // Baud and oversampling counters
    next_s.baudCnt = smpTick ? s.baud : s.baudCnt - 12'h001;
    if (smpTick) begin
      next_s.txSub = (s.txSub == lastSub) ? 4'h0 : s.txSub + 4'h1;
    end
    // Register writes
    if (busReq.wr) begin
      case (busReq.addr)
        `USR_ADDR_CSA: begin
          if (busReq.wdata[`USR_CSA_TX_DONE]) begin
            next_s.txDone = 1'b0;
          end
          next_s.dbl = busReq.wdata[`USR_CSA_DBL];
        end
        `USR_ADDR_CSB: begin
          next_s.cIrqEn  = busReq.wdata[`USR_CSB_TCIE];
          next_s.eIrqEn  = busReq.wdata[`USR_CSB_EIE];
          next_s.receive_enable    = busReq.wdata[`USR_CSB_RX_ON];
          next_s.transmit_enable    = busReq.wdata[`USR_CSB_TX_ON];
          next_s.csz[2]  = busReq.wdata[`USR_CSB_CSZ2];
          next_s.txNinth = busReq.wdata[`USR_CSB_TX9];
        end
        `USR_ADDR_CSC: begin
          next_s.syncMode = busReq.wdata[`USR_CSC_SYNC];
          next_s.parEn    = busReq.wdata[`USR_CSC_PEN];
          next_s.parOdd   = busReq.wdata[`USR_CSC_PODD];
          next_s.stop2    = busReq.wdata[`USR_CSC_STOP2];
          next_s.csz[1:0] = busReq.wdata[`USR_CSC_CSZ_LO +: 2];
        end
        `USR_ADDR_BAUDL: next_s.baud[7:0] = busReq.wdata;
        `USR_ADDR_BAUDH: next_s.baud[11:8] = busReq.wdata[3:0];
        default: ;
      endcase
    end
    if (txDoneAck) begin
      next_s.txDone = 1'b0;
    end
    // Transmitter
    if (txTick) begin
      case (s.txState)
        TX_IDLE: ;
        TX_START: begin
          next_s.txState = TX_DATA;
          next_s.txBit   = 4'h0;
        end
        TX_DATA: begin
          if (s.txBit == usr_char_bits(s.csz) - 4'h1) begin
            next_s.txState = s.parEn ? TX_PAR : TX_STOP1;
          end else begin
            next_s.txShift = {1'b0, s.txShift[8:1]};
            next_s.txBit   = s.txBit + 4'h1;
          end
        end
        TX_PAR:   next_s.txState = TX_STOP1;
        TX_STOP1: begin
          if (s.stop2) begin
            next_s.txState = TX_STOP2;
          end else begin
            finish = 1'b1;
          end
        end
        TX_STOP2: finish = 1'b1;
        default:  next_s.txState = TX_IDLE;
      endcase
      if (s.txBufFull && s.txActive && (s.txState == TX_IDLE || finish)) begin
        next_s.txShift   = s.txBuf;
        next_s.txPar     = usr_parity(s.txBuf, s.csz, s.parOdd);
        next_s.txBufFull = 1'b0;
        next_s.txState   = TX_START;
      end else if (finish) begin
        next_s.txState = TX_IDLE;
        next_s.txDone  = 1'b1;
      end
    end
    if (wrData) begin
      next_s.txBuf     = {s.txNinth, busReq.wdata} & usr_char_mask(s.csz);
      next_s.txBufFull = 1'b1;
    end
    // Transmit enable takes hold at once, lets go only when drained
    if (next_s.transmit_enable) begin
      next_s.txActive = 1'b1;
    end else if (next_s.txState == TX_IDLE && !next_s.txBufFull) begin
      next_s.txActive = 1'b0;
    end
    case (next_s.txState)
      TX_START: next_s.txd = 1'b0;
      TX_DATA:  next_s.txd = next_s.txShift[0];
      TX_PAR:   next_s.txd = next_s.txPar;
      default:  next_s.txd = 1'b1;
    endcase
    // Receiver
    if (rdDataReg) begin
      next_s.rxFull = 1'b0;
    end
    if (s.rxState != RX_IDLE && smpTick) begin
      next_s.rxSub = (s.rxSub == lastSub) ? 4'h0 : s.rxSub + 4'h1;
    end
    case (s.rxState)
      RX_IDLE: begin
        if (s.syncMode ? (syncFall && !rxIn) : (smpTick && !rxIn)) begin
          next_s.rxState = s.syncMode ? RX_DATA : RX_START;
          next_s.rxSub   = 4'h0;
          next_s.rxBit   = 4'h0;
          next_s.rxShift = '0;
        end
      end
      RX_START: begin
        if (smpTick && s.rxSub == (lastSub >> 1)) begin
          next_s.rxState = rxIn ? RX_IDLE : RX_DATA;
          next_s.rxSub   = 4'h0;
        end
      end
      RX_DATA: begin
        if (rxTick) begin
          next_s.rxShift[s.rxBit] = rxIn;
          if (s.rxBit == usr_char_bits(s.csz) - 4'h1) begin
            next_s.rxState = s.parEn ? RX_PAR : RX_STOP;
          end else begin
            next_s.rxBit = s.rxBit + 4'h1;
          end
        end
      end
      RX_PAR: begin
        if (rxTick) begin
          next_s.rxState = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rxTick) begin
          next_s.rxBuf   = s.rxShift;
          next_s.rxFull  = 1'b1;
          next_s.rxState = RX_IDLE;
        end
      end
      default: next_s.rxState = RX_IDLE;
    endcase
    if (!s.receive_enable) begin
      next_s.rxFull  = 1'b0;
      next_s.rxState = RX_IDLE;
    end
    // Read data, valid only the cycle after the strobe
    next_s.rdData = 8'h00;
    if (busReq.rd) begin
      case (busReq.addr)
        `USR_ADDR_DATA:  next_s.rdData = s.rxBuf[7:0];
        `USR_ADDR_CSA:   next_s.rdData = {s.rxFull, s.txDone, ~s.txBufFull, 3'h0,
                                          s.dbl, 1'b0};
        `USR_ADDR_CSB:   next_s.rdData = {1'b0, s.cIrqEn, s.eIrqEn, s.receive_enable, s.transmit_enable,
                                          s.csz[2], s.rxBuf[8], s.txNinth};
        `USR_ADDR_CSC:   next_s.rdData = {1'b0, s.syncMode, s.parEn, s.parOdd, s.stop2,
                                          s.csz[1:0], 1'b0};
        `USR_ADDR_BAUDL: next_s.rdData = s.baud[7:0];
        `USR_ADDR_BAUDH: next_s.rdData = {4'h0, s.baud[11:8]};
        default:         next_s.rdData = 8'h00;
      endcase
    end
    // Pin overrides and interrupt requests
    next_s.syncOvr  = s.syncMode & (s.txActive | s.receive_enable);
    next_s.irqEmpty = s.eIrqEn & ~s.txBufFull;
    next_s.irqDone  = s.cIrqEn & s.txDone;
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s         <= '0;
      s.csz     <= `USR_RST_CSZ;
      s.baud    <= `USR_RST_BAUD;
      s.txState <= TX_IDLE;
      s.rxState <= RX_IDLE;
      s.txd     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdData          = s.rdData;
  assign txd             = s.txd;
  assign txdOverride     = s.txActive;
  assign rxdOverride     = s.receive_enable;
  assign syncClkOverride = s.syncOvr;
  assign irqTxEmpty      = s.irqEmpty;
  assign irqTxDone       = s.irqDone;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_write_fills_buf: assert property (@(posedge clk_sys) disable iff (rst)
    wrData |=> s.txBufFull ##1 !irqTxEmpty)
    else $error("data write did not fill transmit buffer");

  a_empty_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    (s.eIrqEn && !s.txBufFull) |=> irqTxEmpty)
    else $error("buffer-empty request missing");

  a_done_irq_rise: assert property (@(posedge clk_sys) disable iff (rst)
    ($rose(s.txDone) && s.cIrqEn && !txDoneAck) |=> irqTxDone)
    else $error("transmit-complete request missing");

  a_start_bit_low: assert property (@(posedge clk_sys) disable iff (rst)
    (s.txState == TX_START) |-> !txd)
    else $error("start bit level wrong");

  a_stop_bit_high: assert property (@(posedge clk_sys) disable iff (rst)
    (s.txState == TX_STOP1 || s.txState == TX_STOP2) |-> txd)
    else $error("stop bit level wrong");

  a_parity_slot: assert property (@(posedge clk_sys) disable iff (rst)
    (s.txState == TX_PAR) |-> (txd == s.txPar) && s.parEn)
    else $error("parity bit level wrong");

  a_idle_line_high: assert property (@(posedge clk_sys) disable iff (rst)
    (s.txActive && s.txState == TX_IDLE) |-> txd)
    else $error("idle transmitter not high");

  a_disable_release: assert property (@(posedge clk_sys) disable iff (rst)
    (!s.transmit_enable && !busReq.wr && s.txState == TX_IDLE && !s.txBufFull) |=> !txdOverride)
    else $error("transmitter kept the pin");

  a_hold_while_busy: assert property (@(posedge clk_sys) disable iff (rst)
    (s.txState != TX_IDLE) |-> txdOverride)
    else $error("pin released during a frame");

  a_read_clears_rxflag: assert property (@(posedge clk_sys) disable iff (rst)
    (rdDataReg && !(s.rxState == RX_STOP && rxTick)) |=> !s.rxFull)
    else $error("data read left receive flag set");

  a_rx_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
    s.rxFull |-> (s.rxBuf & ~usr_char_mask(s.csz)) == 9'h000)
    else $error("received upper bits not zero");

  a_done_after_stop: assert property (@(posedge clk_sys) disable iff (rst)
    (txTick && s.txState == TX_STOP1 && !s.stop2 && !s.txBufFull && !wrData)
    |=> s.txDone && s.txState == TX_IDLE)
    else $error("transmit-complete not set after frame");

  a_load_on_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (txTick && s.txActive && s.txBufFull && s.txState == TX_IDLE && !wrData)
    |=> s.txState == TX_START && !s.txBufFull)
    else $error("buffered data not moved to shifter");

  a_rx_load_buffer: assert property (@(posedge clk_sys) disable iff (rst)
    (s.receive_enable && s.rxState == RX_STOP && rxTick) |=> s.rxFull && s.rxBuf == $past(s.rxShift))
    else $error("receive buffer not loaded at stop");

  a_rx_off_flush: assert property (@(posedge clk_sys) disable iff (rst)
    !s.receive_enable |=> !s.rxFull)
    else $error("disabled receiver kept data");

endmodule : usr_core

`default_nettype wire

// file: include/usr_params.svh
`ifndef USR_PARAMS_SVH
`define USR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define USR_ADDR_DATA   3'h0
`define USR_ADDR_CSA    3'h1
`define USR_ADDR_CSB    3'h2
`define USR_ADDR_CSC    3'h3
`define USR_ADDR_BAUDL  3'h4
`define USR_ADDR_BAUDH  3'h5

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define USR_CSA_RX_DONE  7
`define USR_CSA_TX_DONE  6
`define USR_CSA_TX_EMPTY 5
`define USR_CSA_DBL     1
`define USR_CSB_TCIE    6
`define USR_CSB_EIE     5
`define USR_CSB_RX_ON   4
`define USR_CSB_TX_ON   3
`define USR_CSB_CSZ2    2
`define USR_CSB_RX9     1
`define USR_CSB_TX9     0
`define USR_CSC_SYNC    6
`define USR_CSC_PEN     5
`define USR_CSC_PODD    4
`define USR_CSC_STOP2   3
`define USR_CSC_CSZ_LO  1

// ----------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------
`define USR_RST_CSZ     3'h3
`define USR_RST_BAUD    12'h000
`define USR_CSZ_NINE    3'h7
`define USR_SMP_NORMAL  4'hf
`define USR_SMP_DOUBLE  4'h7

`endif

// file: include/usr_pkg.sv
package usr_pkg;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [5:0] {
    TX_IDLE  = 6'h01,
    TX_START = 6'h02,
    TX_DATA  = 6'h04,
    TX_PAR   = 6'h08,
    TX_STOP1 = 6'h10,
    TX_STOP2 = 6'h20
  } usr_tx_st_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } usr_rx_st_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } usr_bus_t;

  typedef struct packed {
    logic        txActive;  logic        transmit_enable;     logic        receive_enable;
    logic        eIrqEn;    logic        cIrqEn;   logic        txNinth;
    logic        dbl;       logic        syncMode; logic        parEn;
    logic        parOdd;    logic        stop2;    logic [2:0]  csz;
    logic [11:0] baud;      logic [11:0] baudCnt;  logic        syncPrev;
    logic [3:0]  txSub;     logic [3:0]  rxSub;
    usr_tx_st_t  txState;   logic [8:0]  txShift;  logic [3:0]  txBit;
    logic        txPar;     logic [8:0]  txBuf;    logic        txBufFull;
    logic        txDone;
    usr_rx_st_t  rxState;   logic [8:0]  rxShift;  logic [3:0]  rxBit;
    logic [8:0]  rxBuf;     logic        rxFull;
    logic [7:0]  rdData;    logic        txd;      logic        syncOvr;
    logic        irqEmpty;  logic        irqDone;
  } usr_state_t;

endpackage : usr_pkg

// file: sim/usr_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "usr_params.svh"

module usr_core_tb
  import usr_pkg::*;
();
  typedef struct packed {
    logic [2:0] csz;
    logic       pen;
    logic       odd;
    logic [8:0] d;
  } usr_row_t;

  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  usr_bus_t   busReq = '0;
  logic       syncClkIn = 1'b0;
  logic       txDoneAck = 1'b0;
  logic [7:0] rdData;
  logic       txd, txdOverride, rxd, rxdOverride, syncClkOverride, irqTxEmpty, irqTxDone;
  logic [3:0] nBits = 4'h8;
  logic       parEn = 1'b0;
  logic       parOdd = 1'b0;
  logic [8:0] gotData;
  logic       gotPar, gotStop;
  int         frameCnt, base;
  int         n_fail = 0;
  int         total_checks = 0;
  int         cycles = 0;
  usr_row_t   rows [6] = '{'{3'h0, 1'b0, 1'b0, 9'h0ff}, '{3'h1, 1'b1, 1'b0, 9'h05a},
                           '{3'h2, 1'b1, 1'b1, 9'h081}, '{3'h3, 1'b1, 1'b0, 9'h0a5},
                           '{3'h3, 1'b1, 1'b1, 9'h03c}, '{3'h7, 1'b1, 1'b0, 9'h1c3}};

  usr_core usr_core_inst (.clk_sys(clk_sys), .rst(rst), .busReq(busReq), .rdData(rdData),
    .txd(txd), .txdOverride(txdOverride), .rxd(rxd), .rxdOverride(rxdOverride),
    .syncClkIn(syncClkIn), .syncClkOverride(syncClkOverride), .irqTxEmpty(irqTxEmpty),
    .irqTxDone(irqTxDone), .txDoneAck(txDoneAck));

  usr_remote usr_remote_inst (.clk_sys(clk_sys), .txd(txd), .txdOverride(txdOverride),
    .rxd(rxd), .nBits(nBits), .parEn(parEn), .parOdd(parOdd), .gotData(gotData),
    .gotPar(gotPar), .gotStop(gotStop), .frameCnt(frameCnt));

  always #10 clk_sys = ~clk_sys;

  // ------
  // Helpers
  // ------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq <= '0;
    #1;
    d = rdData;
  endtask : rd

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] v;
    rd(a, v);
    chk(9'(v), 9'(exp), nm);
  endtask : rchk

  task automatic poll(input int b, input logic val);
    logic [7:0] v;
    int k;
    k = 0;
    rd(`USR_ADDR_CSA, v);
    while (v[b] !== val && k < 400) begin
      rd(`USR_ADDR_CSA, v);
      k++;
    end
    chk(9'(v[b]), 9'(val), "status poll");
  endtask : poll

  task automatic wait_frame(input int n);
    int k;
    k = 0;
    while (frameCnt < n && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    chk(9'(frameCnt >= n), 9'h001, "frame seen");
    tick(12);
  endtask : wait_frame

  task automatic sync_step(output logic b);
    @(posedge clk_sys);
    syncClkIn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    syncClkIn <= 1'b0;
    #1;
    b = txd;
  endtask : sync_step

  // ------
  // Main sequence
  // ------
  initial begin
    logic [7:0] v;
    logic [8:0] m;
    logic [10:0] sb;
    int nb;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    tick(1);
    chk(9'(txd), 9'h001, "txd reset");
    chk(9'(txdOverride), 9'h000, "tx pin reset");
    rchk(`USR_ADDR_CSA, 8'h20, "csa reset");
    rchk(`USR_ADDR_CSC, 8'h06, "csc reset");
    rchk(3'h7, 8'h00, "unmapped read");
    $display("test reset done");
    for (int r = 0; r < 6; r++) begin
      nb = (rows[r].csz == 3'h7) ? 9 : rows[r].csz + 5;
      nBits <= 4'(nb);
      parEn <= rows[r].pen;
      parOdd <= rows[r].odd;
      m = 9'((1 << nb) - 1) & rows[r].d;
      wr(`USR_ADDR_CSC, {2'b00, rows[r].pen, rows[r].odd, 1'b0, rows[r].csz[1:0], 1'b0});
      wr(`USR_ADDR_CSB, {5'b00011, rows[r].csz[2], 1'b0, rows[r].d[8]});
      wr(`USR_ADDR_DATA, rows[r].d[7:0]);
      wait_frame(r + 1);
      chk(gotData, m, "tx data");
      if (rows[r].pen) chk(9'(gotPar), 9'(^m ^ rows[r].odd), "tx parity");
      chk(9'(gotStop), 9'h001, "tx stop");
      usr_remote_inst.send_frame(m);
      poll(`USR_CSA_RX_DONE, 1'b1);
      rd(`USR_ADDR_CSB, v);
      chk(9'(v[`USR_CSB_RX9]), 9'(m[8]), "rx ninth");
      rd(`USR_ADDR_DATA, v);
      chk(9'(v), m & 9'h0ff, "rx data");
      poll(`USR_CSA_RX_DONE, 1'b0);
      $display("test row %0d done", r);
    end
    nBits <= 4'h8;
    parEn <= 1'b0;
    wr(`USR_ADDR_CSB, 8'h18);
    wr(`USR_ADDR_CSC, 8'h0e);
    wr(`USR_ADDR_BAUDL, 8'h01);
    wr(`USR_ADDR_CSA, 8'h02);
    rchk(`USR_ADDR_BAUDL, 8'h01, "baud low");
    rchk(`USR_ADDR_CSA, 8'h62, "csa double");
    wr(`USR_ADDR_DATA, 8'h5a);
    wait_frame(7);
    chk(gotData, 9'h05a, "dbl tx data");
    chk(9'(gotStop), 9'h001, "dbl tx stop");
    usr_remote_inst.send_frame(9'h0a5);
    poll(`USR_CSA_RX_DONE, 1'b1);
    rchk(`USR_ADDR_DATA, 8'ha5, "dbl rx data");
    wr(`USR_ADDR_BAUDL, 8'h00);
    wr(`USR_ADDR_CSA, 8'h00);
    $display("test double speed done");
    wr(`USR_ADDR_CSC, 8'h06);
    rchk(`USR_ADDR_CSA, 8'h60, "csa complete");
    wr(`USR_ADDR_CSA, 8'h40);
    rchk(`USR_ADDR_CSA, 8'h20, "csa cleared");
    wr(`USR_ADDR_CSB, 8'h78);
    tick(2);
    chk(9'(txdOverride), 9'h001, "tx pin");
    chk(9'(rxdOverride), 9'h001, "rx pin");
    chk(9'(irqTxEmpty), 9'h001, "empty irq");
    $display("test enables done");
    base = frameCnt;
    wr(`USR_ADDR_DATA, 8'h3c);
    poll(`USR_CSA_TX_EMPTY, 1'b1);
    wr(`USR_ADDR_DATA, 8'hc3);
    tick(2);
    chk(9'(irqTxEmpty), 9'h000, "empty irq full");
    rchk(`USR_ADDR_CSA, 8'h00, "csa full");
    wait_frame(base + 1);
    chk(gotData, 9'h03c, "first frame");
    chk(9'(irqTxDone), 9'h000, "done irq early");
    chk(9'(irqTxEmpty), 9'h001, "empty irq moved");
    wait_frame(base + 2);
    chk(gotData, 9'h0c3, "second frame");
    chk(9'(irqTxDone), 9'h001, "done irq");
    chk(9'(txd), 9'h001, "txd idle");
    @(posedge clk_sys);
    txDoneAck <= 1'b1;
    @(posedge clk_sys);
    txDoneAck <= 1'b0;
    tick(2);
    chk(9'(irqTxDone), 9'h000, "done ack");
    $display("test back to back done");
    wr(`USR_ADDR_DATA, 8'h96);
    wr(`USR_ADDR_CSB, 8'h70);
    tick(1);
    chk(9'(txdOverride), 9'h001, "tx pin held");
    wait_frame(base + 3);
    chk(gotData, 9'h096, "last frame");
    chk(9'(txdOverride), 9'h000, "tx pin freed");
    $display("test disable done");
    wr(`USR_ADDR_CSC, 8'h46);
    tick(2);
    chk(9'(syncClkOverride), 9'h001, "sync pin");
    wr(`USR_ADDR_CSB, 8'h18);
    wr(`USR_ADDR_DATA, 8'h5a);
    for (int i = 0; i < 11; i++) begin
      sync_step(sb[i]);
    end
    chk(9'(sb[8:1]), 9'h05a, "sync tx data");
    chk(9'({sb[10:9], sb[0]}), 9'h006, "sync tx framing");
    wr(`USR_ADDR_CSB, 8'h00);
    tick(2);
    chk(9'(syncClkOverride), 9'h000, "sync pin off");
    chk(9'(rxdOverride), 9'h000, "rx pin off");
    chk(9'(irqTxEmpty), 9'h000, "empty irq off");
    $display("test sync pin done");
    finish_test();
  end
endmodule : usr_core_tb

`default_nettype wire

// file: sim/usr_remote.sv
`timescale 1ns/100ps
`default_nettype none

module usr_remote (
  // Clock
  input  wire logic       clk_sys,
  // Serial lines
  input  wire logic       txd,
  input  wire logic       txdOverride,
  output logic            rxd,
  // Frame format
  input  wire logic [3:0] nBits,
  input  wire logic       parEn,
  input  wire logic       parOdd,
  // Last frame seen
  output logic [8:0]      gotData,
  output logic            gotPar,
  output logic            gotStop,
  output int              frameCnt
);
  // ------
  // Receiver of device frames
  // ------
  initial begin
    rxd = 1'b1;
    gotData = 9'h000;
    gotPar = 1'b0;
    gotStop = 1'b0;
    frameCnt = 0;
  end

  always begin
    @(posedge clk_sys);
    if (txdOverride === 1'b1 && txd === 1'b0) begin
      repeat (8) @(posedge clk_sys);
      gotData = 9'h000;
      for (int i = 0; i < nBits; i++) begin
        repeat (16) @(posedge clk_sys);
        gotData[i] = txd;
      end
      if (parEn) begin
        repeat (16) @(posedge clk_sys);
        gotPar = txd;
      end
      repeat (16) @(posedge clk_sys);
      gotStop = txd;
      frameCnt++;
    end
  end

  // ------
  // Sender of frames to the device
  // ------
  task automatic send_frame(input logic [8:0] d);
    logic p;
    p = parOdd;
    @(posedge clk_sys);
    rxd <= 1'b0;
    repeat (16) @(posedge clk_sys);
    for (int i = 0; i < nBits; i++) begin
      rxd <= d[i];
      p = p ^ d[i];
      repeat (16) @(posedge clk_sys);
    end
    if (parEn) begin
      rxd <= p;
      repeat (16) @(posedge clk_sys);
    end
    rxd <= 1'b1;
    repeat (32) @(posedge clk_sys);
  endtask : send_frame
endmodule : usr_remote

`default_nettype wire
